// *** testbench/pulse_counter_model.sv ***
// downstream pulse receiver: counts pulses and measures their timing
`timescale 1ns/100ps

module pulse_counter_model (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // pulse line
  input wire logic i_pulse,
  // observations
  output logic [31:0] o_count,
  output logic [31:0] o_high_len,
  output logic [31:0] o_low_len
);
  logic last_lvl;
  logic [31:0] run;

  // ==========================================================================
  // run lengths of back-to-back pulses
  always_ff @(posedge i_clock) begin
    last_lvl <= i_pulse;
    if (i_sys_rst) begin
      o_count <= 32'h0;
      run <= 32'h0;
    end else if (i_pulse != last_lvl) begin
      run <= 32'h1;
      if (i_pulse) begin
        o_count <= o_count + 32'h1;
        o_low_len <= run;
      end else begin
        o_high_len <= run;
      end
    end else begin
      run <= run + 32'h1;
    end
  end
endmodule : pulse_counter_model

// *** testbench/pulse_sum_props.sv ***
// port checker for the weighted pulse summator
`timescale 1ns/100ps

module pulse_sum_props #(
  parameter int MS_CYCLES = pulse_sum_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // apb side
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [11:0] i_paddr,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // pulse output
  input wire logic o_pulse_out
);
  localparam int HMIN = int'(pulse_sum_pkg::TRANS_MIN_MS) * MS_CYCLES - 1;
  localparam int HMAX = int'(pulse_sum_pkg::PULSE_MAX_MS) * MS_CYCLES + 1;
  logic [23:0] high_cnt;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  // ==========================================================================
  // helper: cycles the output has stood high
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || !o_pulse_out) begin
      high_cnt <= 24'h000000;
    end else begin
      high_cnt <= high_cnt + 24'h000001;
    end
  end

  // ==========================================================================
  // register access
  a_ready_const: assert property (i_psel && i_penable |-> o_pready)
    else $error("pready low in access cycle");
  a_err_unmapped: assert property (i_psel && i_penable && i_paddr == 12'h014 |-> o_pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (i_psel && i_penable && i_paddr == 12'h000 |-> !o_pslverr)
    else $error("error on control register");
  a_err_holds: assert property (!i_psel |-> $stable(o_pslverr))
    else $error("pslverr changed outside a transfer");

  // ==========================================================================
  // output pulse shape
  a_high_min: assert property ($fell(o_pulse_out) |-> high_cnt >= HMIN)
    else $error("output pulse too short");
  a_high_max: assert property (o_pulse_out |-> high_cnt <= HMAX)
    else $error("output pulse too long");
  a_gap_min: assert property ($fell(o_pulse_out) |-> !o_pulse_out [*8])
    else $error("no low gap after output pulse");
  a_reset_quiet: assert property ($fell(i_sys_rst) |-> !o_pulse_out [*3])
    else $error("output pulse without any input");
endmodule : pulse_sum_props

// *** testbench/weighted_pulse_summator_tb.sv ***
// self-checking bench for the weighted pulse summator
`timescale 1ns/100ps

module weighted_pulse_summator_tb;
  localparam int MSC = 2;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic [5:0] i_pulse_in = 6'h00;
  logic [31:0] o_prdata, mcount, hlen, llen, rdat;
  logic o_pready, o_pslverr, o_pulse_out, perr;
  int mismatches = 0;
  int n_checks = 0;
  logic [15:0] fac [6] = '{16'h0003, 16'h0001, 16'h0002, 16'h0001, 16'h0005, 16'h0001};
  logic [15:0] dv [6] = '{16'h0002, 16'h0001, 16'h0001, 16'h0003, 16'h0001, 16'h0001};
  logic [11:0] ra [6] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h040, 12'h074};
  logic [31:0] rv [6] = '{32'h1, 32'h1F4, 32'h0, 32'h0, 32'h1, 32'h1};

  // clock, 8 ns period
  always #4 i_clock = ~i_clock;

  weighted_pulse_summator #(.MS_CYCLES(MSC), .DEBOUNCE_CYCLES(20)) dut_u (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_pulse_in(i_pulse_in),
    .o_pulse_out(o_pulse_out));

  pulse_counter_model rx_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_pulse(o_pulse_out),
    .o_count(mcount), .o_high_len(hlen), .o_low_len(llen));

  // ==========================================================================
  // apb transfer: setup, access until pready, then release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do @(posedge i_clock); while (o_pready !== 1'b1);
    rdat = o_prdata;
    perr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  // compare and count
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  // one field pulse on the lanes of m, h cycles high then h low
  task automatic pulse(input logic [5:0] m, input int h);
    i_pulse_in <= m;
    repeat (h) @(posedge i_clock);
    i_pulse_in <= 6'h00;
    repeat (h) @(posedge i_clock);
  endtask : pulse

  // wait for n received pulses, then let the last one finish
  task automatic wait_out(input logic [31:0] n, input int tail);
    for (int k = 0; k < 40000 && mcount < n; k++) @(posedge i_clock);
    repeat (tail) @(posedge i_clock);
    chk("received pulses", n, mcount);
  endtask : wait_out

  // verdict
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  // ==========================================================================
  // main sequence
  initial begin
    repeat (10) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset value", rv[i], rdat);
    end
    apb(1'b1, 12'h014, 32'h5);
    chk("unmapped write error", 32'h1, {31'h0, perr});
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped read", 32'h0, rdat);
    apb(1'b1, 12'h000, 32'h2);
    apb(1'b1, 12'h004, 32'd50);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 12'h040 + 12'(4 * i), {16'h0, fac[i]});
      apb(1'b1, 12'h060 + 12'(4 * i), {16'h0, dv[i]});
    end
    repeat (3) pulse(6'h3F, 4);
    pulse(6'h09, 4);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 12'h080 + 12'(4 * i), 32'h0);
      chk("input count", (i == 0 || i == 3) ? 32'h4 : 32'h3, rdat);
    end
    apb(1'b0, 12'h00C, 32'h0);
    chk("pending held", 32'd34, rdat);
    apb(1'b1, 12'h000, 32'h3);
    wait_out(32'd34, 250);
    chk("transistor high", 32'h1, 32'(hlen >= 99 && hlen <= 101));
    chk("transistor low", 32'h1, 32'(llen >= 99 && llen <= 104));
    apb(1'b0, 12'h010, 32'h0);
    chk("output count", 32'd34, rdat);
    apb(1'b1, 12'h008, 32'h4);
    pulse(6'h04, 5);
    pulse(6'h04, 40);
    apb(1'b0, 12'h088, 32'h0);
    chk("debounced count", 32'h4, rdat);
    wait_out(32'd36, 250);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h004, 32'd10);
    // a zero divisor on lane 5 must weigh like one
    apb(1'b1, 12'h074, 32'h0);
    pulse(6'h22, 4);
    wait_out(32'd38, 2100);
    chk("relay high clamped", 32'h1, 32'(hlen >= 999 && hlen <= 1001));
    apb(1'b0, 12'h00C, 32'h0);
    chk("pending drained", 32'h0, rdat);
    close_out();
  end

  // watchdog
  initial begin
    repeat (60000) @(posedge i_clock);
    mismatches++;
    close_out();
  end
endmodule : weighted_pulse_summator_tb

bind weighted_pulse_summator pulse_sum_props #(.MS_CYCLES(MS_CYCLES)) props_u (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_pulse_out(o_pulse_out));

// *** verilog/input_conditioner.sv ***
// input synchroniser with optional contact debounce
`timescale 1ns/100ps

module input_conditioner #(
  parameter int DEBOUNCE_CYCLES = pulse_sum_pkg::DEBOUNCE_CYCLES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // field side
  input wire logic i_pin,
  input wire logic i_contact_mode,
  // conditioned level
  output logic o_level
);

  localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(DEBOUNCE_CYCLES - 1);

  logic meta_reg;
  logic sync_reg;
  logic [CW-1:0] stable_cnt_reg;

  // two flops before any logic reads the pin
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= i_pin;
      sync_reg <= meta_reg;
    end
  end

  // contact debounce filter
  // a contact level is taken only after it stayed put for the whole window
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      stable_cnt_reg <= '0;
      o_level <= 1'b0;
    end else if (!i_contact_mode || sync_reg == o_level) begin
      stable_cnt_reg <= '0;
      o_level <= sync_reg;
    end else if (stable_cnt_reg == LIMIT) begin
      stable_cnt_reg <= '0;
      o_level <= sync_reg;
    end else begin
      stable_cnt_reg <= stable_cnt_reg + CW'(1);
    end
  end

endmodule : input_conditioner

// *** verilog/pulse_sum_pkg.sv ***
// shared constants for the weighted pulse summator
package pulse_sum_pkg;

  // ==========================================================================
  // clock and timing
  localparam int CLOCK_PERIOD_NS = 8;
  localparam int MS_TIME_NS = 1_000_000;
  localparam int MS_CYCLES = (MS_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int DEBOUNCE_TIME_MS = 5;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_MS * MS_CYCLES;

  // ==========================================================================
  // channel counts and widths
  localparam int MAX_INPUTS = 6;
  localparam int FACTOR_WIDTH = 16;
  localparam int DIVISOR_WIDTH = 16;
  localparam int WIDTH_MS_BITS = 13;

  // ==========================================================================
  // output pulse duration limits in ms
  localparam logic [12:0] RELAY_MIN_MS = 13'h01F4;
  localparam logic [12:0] TRANS_MIN_MS = 13'h0032;
  localparam logic [12:0] PULSE_MAX_MS = 13'h1388;

  // ==========================================================================
  // register byte offsets
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] WIDTH_OFFSET = 12'h004;
  localparam logic [11:0] CONTACT_OFFSET = 12'h008;
  localparam logic [11:0] PENDING_OFFSET = 12'h00C;
  localparam logic [11:0] OUT_COUNT_OFFSET = 12'h010;
  localparam logic [11:0] FACTOR_BASE = 12'h040;
  localparam logic [11:0] DIVISOR_BASE = 12'h060;
  localparam logic [11:0] IN_COUNT_BASE = 12'h080;

  // ==========================================================================
  // control fields and reset values
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_TRANSISTOR_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam logic [12:0] WIDTH_RESET = 13'h01F4;
  localparam logic [15:0] FACTOR_RESET = 16'h0001;
  localparam logic [15:0] DIVISOR_RESET = 16'h0001;

  // output pulse sequencer states
  typedef enum logic [1:0] {
    OUT_IDLE = 2'b00,
    OUT_HIGH = 2'b01,
    OUT_LOW = 2'b10
  } out_state_e;

endpackage : pulse_sum_pkg

// *** verilog/weighted_pulse_summator.sv ***
// weighted pulse summator with apb register file and pulse output
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/100ps

module weighted_pulse_summator #(
  parameter int N_INPUTS = pulse_sum_pkg::MAX_INPUTS,
  parameter int MS_CYCLES = pulse_sum_pkg::MS_CYCLES,
  parameter int DEBOUNCE_CYCLES = pulse_sum_pkg::DEBOUNCE_CYCLES,
  parameter logic [1:0] CTRL_PRESET = pulse_sum_pkg::CTRL_RESET,
  parameter logic [12:0] WIDTH_PRESET = pulse_sum_pkg::WIDTH_RESET,
  parameter logic [15:0] FACTOR_PRESET = pulse_sum_pkg::FACTOR_RESET,
  parameter logic [15:0] DIVISOR_PRESET = pulse_sum_pkg::DIVISOR_RESET
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // field pulse inputs
  input wire logic [N_INPUTS-1:0] i_pulse_in,
  // pulse output
  output logic o_pulse_out
);

  localparam int FW = pulse_sum_pkg::FACTOR_WIDTH;
  localparam int DW = pulse_sum_pkg::DIVISOR_WIDTH;
  localparam int AW = DW + 2;
  localparam int MW = $clog2(MS_CYCLES + 1);
  localparam int WB = pulse_sum_pkg::WIDTH_MS_BITS;
  localparam int CB = $clog2(N_INPUTS + 1);
  localparam logic [MW-1:0] MS_LAST = MW'(MS_CYCLES - 1);
  // channel index and register group fields of the byte address
  localparam int CH_LSB = 2;
  localparam int CH_MSB = 4;
  localparam int GRP_LSB = 5;

  // ==========================================================================
  // registers
  logic [1:0] ctrl_reg;
  logic [WB-1:0] width_reg;
  logic [N_INPUTS-1:0] contact_reg;
  logic [FW-1:0] factor_reg [N_INPUTS];
  logic [DW-1:0] divisor_reg [N_INPUTS];
  logic [31:0] in_count_reg [N_INPUTS];
  logic [AW-1:0] acc_reg [N_INPUTS];
  logic [31:0] pending_reg;
  logic [31:0] out_count_reg;
  logic [N_INPUTS-1:0] level;
  logic [N_INPUTS-1:0] level_d_reg;
  logic [N_INPUTS-1:0] credit;
  logic [CB-1:0] credit_sum;
  logic [MW-1:0] tick_cnt_reg;
  logic ms_tick;
  logic [WB-1:0] ms_cnt_reg;
  logic [WB-1:0] width_eff;
  logic start_pulse;
  pulse_sum_pkg::out_state_e state_reg;

  // apb decode
  logic setup_phase;
  logic wr_access;
  logic [2:0] ch_sel;
  logic ch_ok;
  logic hit_factor;
  logic hit_divisor;
  logic hit_in_count;
  logic addr_ok;
  logic [31:0] rd_value;

  assign setup_phase = i_psel && !i_penable;
  assign wr_access = i_psel && i_penable && i_pwrite;
  assign ch_sel = i_paddr[CH_MSB:CH_LSB];
  assign ch_ok = (32'(ch_sel) < N_INPUTS);
  assign hit_factor = (i_paddr[11:GRP_LSB] == pulse_sum_pkg::FACTOR_BASE[11:GRP_LSB])
    && ch_ok;
  assign hit_divisor = (i_paddr[11:GRP_LSB] == pulse_sum_pkg::DIVISOR_BASE[11:GRP_LSB])
    && ch_ok;
  assign hit_in_count = (i_paddr[11:GRP_LSB] == pulse_sum_pkg::IN_COUNT_BASE[11:GRP_LSB])
    && ch_ok;

  // zero-wait slave, error only on unmapped address
  assign o_pready = 1'b1;

  // ==========================================================================
  // read mux
  always_comb begin
    rd_value = 32'h0000_0000;
    addr_ok = 1'b1;
    if (hit_factor) begin
      rd_value = 32'(factor_reg[ch_sel]);
    end else if (hit_divisor) begin
      rd_value = 32'(divisor_reg[ch_sel]);
    end else if (hit_in_count) begin
      rd_value = in_count_reg[ch_sel];
    end else begin
      case (i_paddr)
        pulse_sum_pkg::CTRL_OFFSET: rd_value = 32'(ctrl_reg);
        pulse_sum_pkg::WIDTH_OFFSET: rd_value = 32'(width_reg);
        pulse_sum_pkg::CONTACT_OFFSET: rd_value = 32'(contact_reg);
        pulse_sum_pkg::PENDING_OFFSET: rd_value = pending_reg;
        pulse_sum_pkg::OUT_COUNT_OFFSET: rd_value = out_count_reg;
        default: addr_ok = 1'b0;
      endcase
    end
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (setup_phase) begin
      o_prdata <= i_pwrite ? 32'h0000_0000 : rd_value;
      o_pslverr <= !addr_ok;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ctrl_reg <= CTRL_PRESET;
      width_reg <= WIDTH_PRESET;
      contact_reg <= '0;
    end else if (wr_access) begin
      case (i_paddr)
        pulse_sum_pkg::CTRL_OFFSET: ctrl_reg <= i_pwdata[$bits(ctrl_reg)-1:0];
        pulse_sum_pkg::WIDTH_OFFSET: width_reg <= i_pwdata[WB-1:0];
        pulse_sum_pkg::CONTACT_OFFSET: contact_reg <= i_pwdata[N_INPUTS-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // per-input conditioning, weighting and remainder
  // one lane per input
  generate
    for (genvar g = 0; g < N_INPUTS; g++) begin : g_lane
      logic [AW-1:0] sum;
      logic [AW-1:0] div_eff;
      logic edge_seen;

      input_conditioner #(
        .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
      ) u_cond (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_pin(i_pulse_in[g]),
        .i_contact_mode(contact_reg[g]),
        .o_level(level[g])
      );

      assign edge_seen = level[g] && !level_d_reg[g];
      // zero divisor behaves as one
      assign div_eff = (divisor_reg[g] == '0) ? AW'(1) : AW'(divisor_reg[g]);
      assign sum = acc_reg[g] + (edge_seen ? AW'(factor_reg[g]) : '0);
      // one credit per whole divisor reached
      assign credit[g] = (sum >= div_eff);

      always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
          factor_reg[g] <= FACTOR_PRESET;
          divisor_reg[g] <= DIVISOR_PRESET;
        end else if (wr_access && 32'(ch_sel) == g) begin
          if (hit_factor) begin
            factor_reg[g] <= i_pwdata[FW-1:0];
          end
          if (hit_divisor) begin
            divisor_reg[g] <= i_pwdata[DW-1:0];
          end
        end
      end

      always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
          acc_reg[g] <= '0;
          in_count_reg[g] <= 32'h0000_0000;
        end else begin
          acc_reg[g] <= credit[g] ? (sum - div_eff) : sum;
          if (edge_seen) begin
            in_count_reg[g] <= in_count_reg[g] + 32'h0000_0001;
          end
        end
      end
    end
  endgenerate

  // edge history of conditioned levels
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      level_d_reg <= '0;
    end else begin
      level_d_reg <= level;
    end
  end

  // credits of all lanes added in one cycle
  always_comb begin
    credit_sum = '0;
    for (int k = 0; k < N_INPUTS; k++) begin
      credit_sum = credit_sum + CB'(credit[k]);
    end
  end

  // ==========================================================================
  // pending output pulses
  // backlog counter, arrivals never lost
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      pending_reg <= 32'h0000_0000;
    end else begin
      pending_reg <= pending_reg + 32'(credit_sum) - (start_pulse ? 32'h1 : 32'h0);
    end
  end

  // millisecond time base
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || state_reg == pulse_sum_pkg::OUT_IDLE) begin
      tick_cnt_reg <= '0;
    end else if (tick_cnt_reg == MS_LAST) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + MW'(1);
    end
  end
  assign ms_tick = (tick_cnt_reg == MS_LAST);

  // duration clamped to the output type range
  always_comb begin
    width_eff = width_reg;
    if (width_reg > pulse_sum_pkg::PULSE_MAX_MS) begin
      width_eff = pulse_sum_pkg::PULSE_MAX_MS;
    end else if (ctrl_reg[pulse_sum_pkg::CTRL_TRANSISTOR_BIT]) begin
      if (width_reg < pulse_sum_pkg::TRANS_MIN_MS) begin
        width_eff = pulse_sum_pkg::TRANS_MIN_MS;
      end
    end else if (width_reg < pulse_sum_pkg::RELAY_MIN_MS) begin
      width_eff = pulse_sum_pkg::RELAY_MIN_MS;
    end
  end

  assign start_pulse = (state_reg == pulse_sum_pkg::OUT_IDLE) && (pending_reg != '0)
    && ctrl_reg[pulse_sum_pkg::CTRL_ENABLE_BIT];

  // high then low gap one clock longer (idle cycle), near 50% duty when back to back
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_reg <= pulse_sum_pkg::OUT_IDLE;
      ms_cnt_reg <= '0;
      o_pulse_out <= 1'b0;
      out_count_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        pulse_sum_pkg::OUT_IDLE: begin
          ms_cnt_reg <= '0;
          if (start_pulse) begin
            state_reg <= pulse_sum_pkg::OUT_HIGH;
            o_pulse_out <= 1'b1;
            out_count_reg <= out_count_reg + 32'h0000_0001;
          end
        end
        pulse_sum_pkg::OUT_HIGH: begin
          if (ms_tick) begin
            if (ms_cnt_reg == width_eff - WB'(1)) begin
              ms_cnt_reg <= '0;
              state_reg <= pulse_sum_pkg::OUT_LOW;
              o_pulse_out <= 1'b0;
            end else begin
              ms_cnt_reg <= ms_cnt_reg + WB'(1);
            end
          end
        end
        pulse_sum_pkg::OUT_LOW: begin
          if (ms_tick) begin
            if (ms_cnt_reg == width_eff - WB'(1)) begin
              ms_cnt_reg <= '0;
              state_reg <= pulse_sum_pkg::OUT_IDLE;
            end else begin
              ms_cnt_reg <= ms_cnt_reg + WB'(1);
            end
          end
        end
        default: begin
          state_reg <= pulse_sum_pkg::OUT_IDLE;
          o_pulse_out <= 1'b0;
        end
      endcase
    end
  end

endmodule : weighted_pulse_summator
